/* inc/crmb_params.svh */
// Purpose: constants for the receive mask and buffer status block
// Assumes: 32-bit APB data, 16-bit register contents in the low bits
// Notes:   definitions only
`ifndef CRMB_PARAMS_SVH
`define CRMB_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CRMB_OFS_MSK_STD0  12'h000
`define CRMB_OFS_MSK_EXT0  12'h004
`define CRMB_OFS_MSK_STD1  12'h008
`define CRMB_OFS_MSK_EXT1  12'h00C
`define CRMB_OFS_MSK_STD2  12'h010
`define CRMB_OFS_MSK_EXT2  12'h014
`define CRMB_OFS_FULL_LO   12'h018
`define CRMB_OFS_FULL_HI   12'h01C
`define CRMB_OFS_OVF_LO    12'h020
`define CRMB_OFS_OVF_HI    12'h024

// ----------------------------------------
// standard mask word fields
// ----------------------------------------
`define CRMB_STD_SID_HI    15
`define CRMB_STD_SID_LO    5
`define CRMB_STD_ID_TYPE_MATCH_ENABLE      3
`define CRMB_STD_EID_HI    1
`define CRMB_STD_EID_LO    0
`define CRMB_STD_WMASK     16'hFFEB

// ----------------------------------------
// reset values and fills
// ----------------------------------------
`define CRMB_RST_MASK      16'h0000
`define CRMB_RST_FLAGS     16'h0000
`define CRMB_ALL_ONES16    16'hFFFF
`define CRMB_RD_ZERO       32'h0000_0000

`endif

/* inc/crmb_pkg.sv */
// Purpose: types for the receive mask and buffer status block
// Assumes: nothing beyond the constants header
// Notes:   mask source codes follow the filter mask source field
package crmb_pkg;
	typedef logic [10:0] crmb_sid_t;
	typedef logic [17:0] crmb_eid_t;
	typedef logic [15:0] crmb_word_t;
	typedef logic [4:0]  crmb_buf_t;
	typedef enum logic [1:0] {
		CRMB_MSK_SET0 = 2'h0,
		CRMB_MSK_SET1 = 2'h1,
		CRMB_MSK_SET2 = 2'h2,
		CRMB_MSK_NONE = 2'h3
	} crmb_msk_src_t;
endpackage : crmb_pkg

/* inc/crmb_flag_if.sv */
// Purpose: carries set, clear-write and value of one flag word
// Assumes: single clock domain
// Notes:   core drives requests, flags module holds the value
`timescale 1ns/1ps
interface crmb_flag_if #(parameter int W = 16);
	logic [W-1:0] set_vec;
	logic [W-1:0] wr_data;
	logic         wr_en;
	logic [W-1:0] value;
	modport core  (output set_vec, output wr_data, output wr_en, input value);
	modport flags (input set_vec, input wr_data, input wr_en, output value);
endinterface : crmb_flag_if

/* rtl/crmb_flags.sv */
// Purpose: one word of hardware-set, write-zero-to-clear flags
// Assumes: set and clear may arrive in the same cycle
// Notes:   set wins so no event is lost
`timescale 1ns/1ps
`include "crmb_params.svh"
module crmb_flags import crmb_pkg::*; #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// flag word
	crmb_flag_if.flags fl
);
	logic [W-1:0] keep_mask;

	// writing one keeps, writing zero clears
	assign keep_mask = fl.wr_en ? fl.wr_data : {W{1'b1}};

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// reset zero, write-zero clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl.value <= W'(`CRMB_RST_FLAGS);
		end else if (ce) begin
			fl.value <= (fl.value & keep_mask) | fl.set_vec;
		end
	end
endmodule : crmb_flags

/* rtl/crmb_top.sv */
// Purpose: acceptance masking and receive buffer full/overflow status
// Assumes: frame and filter inputs are valid while rx_valid is high
// Notes:   one APB wait state on every access
`timescale 1ns/1ps
`include "crmb_params.svh"
module crmb_top import crmb_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output      logic [31:0]       prdata,
	output      logic              pready,
	output      logic              pslverr,
	// received frame from protocol engine
	input  wire logic              rx_valid,
	input  wire logic              rx_ide,
	input  wire crmb_sid_t         rx_sid,
	input  wire crmb_eid_t         rx_eid,
	input  wire crmb_buf_t         rx_buf_idx,
	// filter that the frame is tested against
	input  wire crmb_sid_t         flt_sid,
	input  wire crmb_eid_t         flt_eid,
	input  wire logic              flt_filter_extended_select,
	input  wire crmb_msk_src_t     flt_mask_src,
	// result towards buffer writer
	output      logic              frame_accept,
	output      logic              frame_store,
	output      logic              frame_overflow,
	output      crmb_buf_t         frame_buf_idx
);
	// ----------------------------------------
	// mask registers
	// ----------------------------------------
	crmb_word_t msk_std_reg [3];
	crmb_word_t msk_ext_reg [3];

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic [ADDR_W-1:0] ofs;
	logic              acc_phase;
	logic              fire;
	logic              wr_fire;
	logic              hit_std0;
	logic              hit_ext0;
	logic              hit_std1;
	logic              hit_ext1;
	logic              hit_std2;
	logic              hit_ext2;
	logic              hit_full_lo;
	logic              hit_full_hi;
	logic              hit_ovf_lo;
	logic              hit_ovf_hi;
	logic              hit_any;
	crmb_word_t        rd_word;

	assign ofs         = paddr;
	assign acc_phase   = ce & psel & penable;
	assign fire        = acc_phase & pready;
	assign wr_fire     = fire & pwrite;
	assign hit_std0    = ofs == ADDR_W'(`CRMB_OFS_MSK_STD0);
	assign hit_ext0    = ofs == ADDR_W'(`CRMB_OFS_MSK_EXT0);
	assign hit_std1    = ofs == ADDR_W'(`CRMB_OFS_MSK_STD1);
	assign hit_ext1    = ofs == ADDR_W'(`CRMB_OFS_MSK_EXT1);
	assign hit_std2    = ofs == ADDR_W'(`CRMB_OFS_MSK_STD2);
	assign hit_ext2    = ofs == ADDR_W'(`CRMB_OFS_MSK_EXT2);
	assign hit_full_lo = ofs == ADDR_W'(`CRMB_OFS_FULL_LO);
	assign hit_full_hi = ofs == ADDR_W'(`CRMB_OFS_FULL_HI);
	assign hit_ovf_lo  = ofs == ADDR_W'(`CRMB_OFS_OVF_LO);
	assign hit_ovf_hi  = ofs == ADDR_W'(`CRMB_OFS_OVF_HI);
	assign hit_any     = hit_std0 | hit_ext0 | hit_std1 | hit_ext1 | hit_std2
	                   | hit_ext2 | hit_full_lo | hit_full_hi | hit_ovf_lo | hit_ovf_hi;

	// ----------------------------------------
	// flag words
	// ----------------------------------------
	crmb_flag_if #(.W(16)) full_lo_if ();
	crmb_flag_if #(.W(16)) full_hi_if ();
	crmb_flag_if #(.W(16)) ovf_lo_if ();
	crmb_flag_if #(.W(16)) ovf_hi_if ();

	crmb_flags #(.W(16)) u_full_lo (.pclk(pclk), .presetn(presetn), .ce(ce), .fl(full_lo_if));
	crmb_flags #(.W(16)) u_full_hi (.pclk(pclk), .presetn(presetn), .ce(ce), .fl(full_hi_if));
	crmb_flags #(.W(16)) u_ovf_lo  (.pclk(pclk), .presetn(presetn), .ce(ce), .fl(ovf_lo_if));
	crmb_flags #(.W(16)) u_ovf_hi  (.pclk(pclk), .presetn(presetn), .ce(ce), .fl(ovf_hi_if));

	logic [31:0] full_all;
	logic [31:0] ovf_all;

	assign full_all = {full_hi_if.value, full_lo_if.value};
	assign ovf_all  = {ovf_hi_if.value, ovf_lo_if.value};

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	assign rd_word = hit_std0    ? msk_std_reg[0]   :
	                 hit_ext0    ? msk_ext_reg[0]   :
	                 hit_std1    ? msk_std_reg[1]   :
	                 hit_ext1    ? msk_ext_reg[1]   :
	                 hit_std2    ? msk_std_reg[2]   :
	                 hit_ext2    ? msk_ext_reg[2]   :
	                 hit_full_lo ? full_lo_if.value :
	                 hit_full_hi ? full_hi_if.value :
	                 hit_ovf_lo  ? ovf_lo_if.value  :
	                 hit_ovf_hi  ? ovf_hi_if.value  : `CRMB_RST_MASK;

	// ----------------------------------------
	// apb response
	// ----------------------------------------
	// one wait state keeps every output a flop; data sampled at access start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `CRMB_RD_ZERO;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit_any;
			if (psel & penable & ~pready) begin
				prdata <= (pwrite | ~hit_any) ? `CRMB_RD_ZERO : {16'h0000, rd_word};
			end
		end
	end

	// ----------------------------------------
	// mask register writes
	// ----------------------------------------
	logic [2:0] wr_std;
	logic [2:0] wr_ext;
	crmb_word_t std_wdata;

	assign wr_std    = {3{wr_fire}} & {hit_std2, hit_std1, hit_std0};
	assign wr_ext    = {3{wr_fire}} & {hit_ext2, hit_ext1, hit_ext0};
	assign std_wdata = pwdata[15:0] & `CRMB_STD_WMASK;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++) begin
				msk_std_reg[i] <= `CRMB_RST_MASK;
				msk_ext_reg[i] <= `CRMB_RST_MASK;
			end
		end else if (ce) begin
			for (int i = 0; i < 3; i++) begin
				if (wr_std[i]) msk_std_reg[i] <= std_wdata;
				if (wr_ext[i]) msk_ext_reg[i] <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// acceptance match
	// ----------------------------------------
	crmb_word_t sel_std;
	crmb_word_t sel_ext;
	logic       use_mask;
	crmb_sid_t  sid_mask;
	crmb_eid_t  eid_mask;
	logic       type_match_en;
	crmb_sid_t  sid_diff;
	crmb_eid_t  eid_diff;
	logic       id_match;
	logic       type_ok;
	logic       match;

	// mask source select, none means exact
	assign use_mask = flt_mask_src != CRMB_MSK_NONE;
	assign sel_std  = (flt_mask_src == CRMB_MSK_SET0) ? msk_std_reg[0] :
	                  (flt_mask_src == CRMB_MSK_SET1) ? msk_std_reg[1] : msk_std_reg[2];
	assign sel_ext  = (flt_mask_src == CRMB_MSK_SET0) ? msk_ext_reg[0] :
	                  (flt_mask_src == CRMB_MSK_SET1) ? msk_ext_reg[1] : msk_ext_reg[2];
	assign sid_mask = use_mask ? sel_std[`CRMB_STD_SID_HI:`CRMB_STD_SID_LO] : '1;
	assign eid_mask = use_mask ? {sel_std[`CRMB_STD_EID_HI:`CRMB_STD_EID_LO], sel_ext} : '1;
	assign type_match_en = use_mask ? sel_std[`CRMB_STD_ID_TYPE_MATCH_ENABLE] : 1'b1;

	assign sid_diff = (rx_sid ^ flt_sid) & sid_mask;
	assign eid_diff = (rx_eid ^ flt_eid) & eid_mask;
	// extended bits count only for extended frames
	assign id_match = ~|sid_diff & (~rx_ide | ~|eid_diff);
	// format check gated by type match
	assign type_ok  = ~type_match_en | (rx_ide == flt_filter_extended_select);
	assign match    = id_match & type_ok;

	// ----------------------------------------
	// buffer flag update
	// ----------------------------------------
	logic        take;
	logic        buf_full;
	logic        do_store;
	logic        do_ovf;
	logic [31:0] buf_onehot;
	logic [31:0] set_full;
	logic [31:0] set_ovf;

	assign take       = ce & rx_valid & match;
	assign buf_full   = full_all[rx_buf_idx];
	assign buf_onehot = 32'h0000_0001 << rx_buf_idx;
	assign do_store   = take & ~buf_full;
	assign do_ovf     = take & buf_full;
	assign set_full   = do_store ? buf_onehot : 32'h0000_0000;
	assign set_ovf    = do_ovf ? buf_onehot : 32'h0000_0000;

	assign full_lo_if.set_vec = set_full[15:0];
	assign full_hi_if.set_vec = set_full[31:16];
	assign ovf_lo_if.set_vec  = set_ovf[15:0];
	assign ovf_hi_if.set_vec  = set_ovf[31:16];

	assign full_lo_if.wr_en   = wr_fire & hit_full_lo;
	assign full_hi_if.wr_en   = wr_fire & hit_full_hi;
	assign ovf_lo_if.wr_en    = wr_fire & hit_ovf_lo;
	assign ovf_hi_if.wr_en    = wr_fire & hit_ovf_hi;
	assign full_lo_if.wr_data = pwdata[15:0];
	assign full_hi_if.wr_data = pwdata[15:0];
	assign ovf_lo_if.wr_data  = pwdata[15:0];
	assign ovf_hi_if.wr_data  = pwdata[15:0];

	// ----------------------------------------
	// result outputs
	// ----------------------------------------
	// store strobe withheld on overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_accept   <= 1'b0;
			frame_store    <= 1'b0;
			frame_overflow <= 1'b0;
			frame_buf_idx  <= '0;
		end else if (ce) begin
			frame_accept   <= take;
			frame_store    <= do_store;
			frame_overflow <= do_ovf;
			frame_buf_idx  <= rx_buf_idx;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_access;
		ce && psel && penable && !pready;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	a_apb_one_wait: assert property (s_access |=> s_answer)
		else $error("apb answer not after one wait");

	a_unimpl_zero: assert property (
		(msk_std_reg[0][4] | msk_std_reg[0][2] | msk_std_reg[1][4] | msk_std_reg[1][2]
		 | msk_std_reg[2][4] | msk_std_reg[2][2]) == 1'b0)
		else $error("unimplemented mask bit set");

	a_accept_match: assert property (
		ce && rx_valid |=> frame_accept == $past(match))
		else $error("accept differs from masked compare");

	a_type_gate: assert property (
		ce && rx_valid && type_match_en && (rx_ide != flt_filter_extended_select) |=> !frame_accept)
		else $error("wrong frame type accepted");

	a_type_ignored: assert property (
		ce && rx_valid && !type_match_en && id_match |=> frame_accept)
		else $error("id match rejected without type match");

	a_full_set: assert property (
		do_store |=> full_all[$past(rx_buf_idx)] && frame_store)
		else $error("full flag not set on store");

	a_ovf_set: assert property (
		do_ovf |=> ovf_all[$past(rx_buf_idx)] && frame_overflow)
		else $error("overflow flag not set");

	a_no_overwrite: assert property (
		do_ovf |=> !frame_store ##1 (!ce || frame_store == $past(do_store)))
		else $error("store strobe on full buffer");

	a_one_keeps: assert property (
		wr_fire && hit_full_lo |=> (full_lo_if.value & $past(full_lo_if.value))
		                           == ($past(full_lo_if.value) & $past(pwdata[15:0])))
		else $error("write one changed a full flag");

	a_zero_clears: assert property (
		wr_fire && hit_ovf_hi && (pwdata[15:0] == 16'h0000) && !(|set_ovf[31:16])
		|=> ovf_hi_if.value == 16'h0000)
		else $error("zero write did not clear overflow");

	a_freeze: assert property (!ce |=> $stable(full_all) && $stable(ovf_all))
		else $error("flags moved while disabled");
endmodule : crmb_top

/* testbench/crmb_frame_src.sv */
// Purpose: stands in for the protocol engine that hands over frames
// Assumes: one frame per call, filter supplied with it
// Notes:   identifiers turn to their inverse between frames
`timescale 1ns/1ps
module crmb_frame_src import crmb_pkg::*; (
	// clock
	input  wire logic          pclk,
	// frame and filter toward the block
	output      logic          rx_valid,
	output      logic          rx_ide,
	output      crmb_sid_t     rx_sid,
	output      crmb_eid_t     rx_eid,
	output      crmb_buf_t     rx_buf_idx,
	output      crmb_sid_t     flt_sid,
	output      crmb_eid_t     flt_eid,
	output      logic          flt_filter_extended_select,
	output      crmb_msk_src_t flt_mask_src
);
	initial begin
		rx_valid = 1'b0;
		{rx_ide, rx_sid, rx_eid, rx_buf_idx, flt_sid, flt_eid, flt_filter_extended_select} = '0;
		flt_mask_src = CRMB_MSK_SET0;
	end

	task automatic send(input logic ide, input crmb_sid_t standard_identifier_bits, input crmb_eid_t extended_identifier_bits,
		input crmb_buf_t b, input crmb_sid_t fs, input crmb_eid_t fe, input logic fx,
		input crmb_msk_src_t s);
		@(posedge pclk);
		rx_valid     <= 1'b1;
		rx_ide       <= ide;
		rx_sid       <= standard_identifier_bits;
		rx_eid       <= extended_identifier_bits;
		rx_buf_idx   <= b;
		flt_sid      <= fs;
		flt_eid      <= fe;
		flt_filter_extended_select    <= fx;
		flt_mask_src <= s;
		@(posedge pclk);
		rx_valid <= 1'b0;
		// stale identifiers must never pass for a new frame
		rx_sid   <= ~standard_identifier_bits;
		rx_eid   <= ~extended_identifier_bits;
		flt_sid  <= ~fs;
		flt_eid  <= ~fe;
	endtask : send
endmodule : crmb_frame_src

/* testbench/tb_crmb_top.sv */
// Purpose: register and frame tests of the mask and buffer status block
// Assumes: one wait state apb slave, clock enable low only in its own test
// Notes:   expected flags kept in a bench-side model
`timescale 1ns/1ps
`include "crmb_params.svh"
module tb_crmb_top import crmb_pkg::*; ;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rd, full_m, ovf_m;
	logic          err, rx_valid, rx_ide, flt_filter_extended_select, ce;
	logic          frame_accept, frame_store, frame_overflow;
	crmb_sid_t     rx_sid, flt_sid;
	crmb_eid_t     rx_eid, flt_eid;
	crmb_buf_t     rx_buf_idx, frame_buf_idx;
	crmb_msk_src_t flt_mask_src;
	logic [15:0]   std_m [3];
	logic [15:0]   ext_m [3];
	int            bad_count, compares, cycles;

	always #5 pclk = ~pclk;

	crmb_top u_crmb_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_ide, .rx_sid, .rx_eid,
		.rx_buf_idx, .flt_sid, .flt_eid, .flt_filter_extended_select, .flt_mask_src, .frame_accept,
		.frame_store, .frame_overflow, .frame_buf_idx);
	crmb_frame_src u_crmb_frame_src (.pclk, .rx_valid, .rx_ide, .rx_sid, .rx_eid,
		.rx_buf_idx, .flt_sid, .flt_eid, .flt_filter_extended_select, .flt_mask_src);

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	task automatic stop_test;
		$display("counts compares=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// hang guard, far above the few hundred cycles the tests need
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends a wait that never gets an answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0000_0000);
		chk32(rd, exp);
		chk1(err, e);
	endtask : rd_chk

	task automatic chk_flags;
		rd_chk(`CRMB_OFS_FULL_LO, {16'h0000, full_m[15:0]}, 1'b0);
		rd_chk(`CRMB_OFS_FULL_HI, {16'h0000, full_m[31:16]}, 1'b0);
		rd_chk(`CRMB_OFS_OVF_LO, {16'h0000, ovf_m[15:0]}, 1'b0);
		rd_chk(`CRMB_OFS_OVF_HI, {16'h0000, ovf_m[31:16]}, 1'b0);
	endtask : chk_flags

	// ----------------------------------------
	// frame acceptance
	// ----------------------------------------
	function automatic logic exp_match(input crmb_msk_src_t s, input logic ide,
		input crmb_sid_t standard_identifier_bits, input crmb_eid_t extended_identifier_bits, input crmb_sid_t fs,
		input crmb_eid_t fe, input logic fx);
		logic [15:0] ms, me;
		ms = (s == CRMB_MSK_NONE) ? 16'hFFFF : std_m[s];
		me = (s == CRMB_MSK_NONE) ? 16'hFFFF : ext_m[s];
		return (((standard_identifier_bits ^ fs) & ms[15:5]) == 11'h000)
			&& (!ide || (((extended_identifier_bits ^ fe) & {ms[1:0], me}) == 18'h00000))
			&& (!ms[3] || (ide == fx));
	endfunction : exp_match

	task automatic frame(input crmb_msk_src_t s, input logic ide, input crmb_sid_t standard_identifier_bits,
		input crmb_eid_t extended_identifier_bits, input crmb_sid_t fs, input crmb_eid_t fe, input logic fx,
		input crmb_buf_t b);
		logic m, f;
		m = exp_match(s, ide, standard_identifier_bits, extended_identifier_bits, fs, fe, fx);
		f = full_m[b];
		u_crmb_frame_src.send(ide, standard_identifier_bits, extended_identifier_bits, b, fs, fe, fx, s);
		#1;
		chk1(frame_accept, m);
		chk1(frame_store, m & !f);
		chk1(frame_overflow, m & f);
		if (m) begin
			chk32({27'h0, frame_buf_idx}, {27'h0, b});
			full_m[b] = 1'b1;
			ovf_m[b]  = ovf_m[b] | f;
		end
	endtask : frame

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		ce      = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{bad_count, compares, cycles} = '0;
		full_m = '0;
		ovf_m  = '0;
		std_m  = '{16'hFFE0, 16'h000B, 16'hAAAA};
		ext_m  = '{16'h0000, 16'h00FF, 16'h5555};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) rd_chk(12'(i * 4), 32'h0, 1'b0);
		$display("test reset_values done");
		apb(1'b1, `CRMB_OFS_MSK_STD0, 32'hFFFF_FFFF);
		rd_chk(`CRMB_OFS_MSK_STD0, 32'h0000_FFEB, 1'b0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'(i * 8), {16'h0000, std_m[i]});
			apb(1'b1, 12'(i * 8 + 4), {16'h0000, ext_m[i]});
		end
		for (int i = 0; i < 3; i++) begin
			rd_chk(12'(i * 8), {16'h0000, std_m[i]}, 1'b0);
			rd_chk(12'(i * 8 + 4), {16'h0000, ext_m[i]}, 1'b0);
		end
		rd_chk(12'h040, 32'h0, 1'b1);
		$display("test mask_registers done");
		frame(CRMB_MSK_SET0, 1'b0, 11'h123, 18'h00000, 11'h123, 18'h00000, 1'b0, 5'd3);
		frame(CRMB_MSK_SET0, 1'b0, 11'h124, 18'h00000, 11'h123, 18'h00000, 1'b0, 5'd4);
		frame(CRMB_MSK_SET0, 1'b1, 11'h123, 18'h3FFFF, 11'h123, 18'h00000, 1'b1, 5'd3);
		frame(CRMB_MSK_SET1, 1'b0, 11'h7FF, 18'h00000, 11'h000, 18'h00000, 1'b1, 5'd5);
		frame(CRMB_MSK_SET1, 1'b1, 11'h7FF, 18'h01234, 11'h000, 18'h0FF34, 1'b1, 5'd20);
		frame(CRMB_MSK_SET1, 1'b1, 11'h7FF, 18'h11234, 11'h000, 18'h0FF34, 1'b1, 5'd21);
		frame(CRMB_MSK_SET2, 1'b0, 11'h555, 18'h00000, 11'h555, 18'h00000, 1'b0, 5'd16);
		frame(CRMB_MSK_SET2, 1'b0, 11'h555, 18'h00000, 11'h555, 18'h00000, 1'b1, 5'd17);
		frame(CRMB_MSK_NONE, 1'b1, 11'h0AB, 18'h2AAAA, 11'h0AB, 18'h2AAAA, 1'b1, 5'd31);
		frame(CRMB_MSK_NONE, 1'b1, 11'h0AB, 18'h2AAAB, 11'h0AB, 18'h2AAAA, 1'b1, 5'd30);
		frame(CRMB_MSK_NONE, 1'b1, 11'h0AB, 18'h2AAAA, 11'h0AB, 18'h2AAAA, 1'b0, 5'd30);
		frame(CRMB_MSK_NONE, 1'b1, 11'h0AB, 18'h2AAAA, 11'h0AB, 18'h2AAAA, 1'b1, 5'd31);
		chk_flags();
		$display("test frame_matching done");
		// writing ones leaves flags, zero clears only its own bit
		apb(1'b1, `CRMB_OFS_FULL_LO, 32'hFFFF_FFF7);
		apb(1'b1, `CRMB_OFS_FULL_HI, 32'h0000_FFFF);
		apb(1'b1, `CRMB_OFS_OVF_LO, 32'h0000_0000);
		full_m[3]     = 1'b0;
		ovf_m[15:0]   = 16'h0000;
		chk_flags();
		frame(CRMB_MSK_SET0, 1'b0, 11'h123, 18'h00000, 11'h123, 18'h00000, 1'b0, 5'd3);
		chk_flags();
		$display("test flag_clear done");
		// a matching frame offered while disabled must be ignored
		@(posedge pclk);
		ce <= 1'b0;
		u_crmb_frame_src.send(1'b0, 11'h555, 18'h00000, 5'd7, 11'h555, 18'h00000, 1'b0,
			CRMB_MSK_SET2);
		#1;
		chk1(frame_accept, 1'b0);
		chk1(frame_store, 1'b0);
		@(posedge pclk);
		ce <= 1'b1;
		chk_flags();
		$display("test clock_enable done");
		// reset in mid-run clears flags and masks again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		full_m = '0;
		ovf_m  = '0;
		chk_flags();
		rd_chk(`CRMB_OFS_MSK_STD2, 32'h0, 1'b0);
		$display("test mid_reset done");
		stop_test();
	end
endmodule : tb_crmb_top
